/* rtl/athsp_dev.sv */
// Purpose: Controller end of the AT host status and control ports.
// Assumes: Drive pins are synchronised here; micro uses a plain port.
// Notes:   Micro reads return data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Status from drive register chosen by drive bit
// - Primary status read clears host interrupt
// - Busy set by command write and reset
// - Ready bit is micro copy; abort if low (no abort here, left to firmware)
// - Write fault micro copy; abort if high (no abort here, left to firmware)
// - Seek complete written by micro
// - Data request driven by buffer manager
// - Corrected flag written by micro
// - Index bit tracks index pin live
// - Error summary bit written by micro
// - Command write latches, busy, micro irq, clears irq
// - Alternate status equals primary status
// - Fixed disk passes all eight bits
// - Head3 enable selects head3 or write current
// - Soft reset bit drives reset output
// - Host holds soft reset five microseconds
// - Reset disabled: micro irq instead of output
// - Interrupt disable bit gates and floats pin
// - Disable keeps pending, blocks new interrupts
// - Master reset clears irq, keeps disable bit
// - Digital input port layout, bit 7 floats
// - Bit 5 head3 or micro write current
// - Task copy blocked while busy, reads status
module athsp_dev
    import athsp_pkg::*;
(
    input  wire logic       clk,          // 100 MHz clock
    input  wire logic       rst,          // Power-qualified reset
    input  wire logic       master_rst,   // System master reset, synchronous
    athsp_if.dev            hp,           // Host port
    input  wire logic [2:0] u_addr,       // Micro address
    input  wire logic [7:0] u_wdata,      // Micro write data
    input  wire logic       u_wr,         // Micro write strobe
    input  wire logic       u_rd,         // Micro read strobe
    output logic      [7:0] u_rdata,      // Micro read data
    output logic            micro_int,    // Interrupt to micro
    input  wire logic       drq_in,       // Buffer manager data request
    input  wire logic       index_pin,    // Drive index pin
    input  wire logic       write_gate,   // Write gate output state
    output logic            reset_out,    // Board reset output
    output logic            hs3_rwc,      // Head select 3 or write current
    output logic      [7:0] sdh_out       // Drive/head select copy
);
    logic [6:0] drv0_q, drv1_q;
    logic [7:0] cmd_q, fixed_q, sdh_q;
    logic       busy_q, irq_q, mint_q, rwc_q, rdis_q, srst_q;
    logic       idx_s1_q, idx_s2_q, drq_s1_q, drq_s2_q, wg_s1_q, wg_s2_q;
    logic [7:0] status;
    logic       cmd_wr, fd_wr, srst_rise, dev_reset;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_s1_q <= 1'b0; idx_s2_q <= 1'b0;
            drq_s1_q <= 1'b0; drq_s2_q <= 1'b0;
            wg_s1_q  <= 1'b0; wg_s2_q  <= 1'b0;
        end else begin
            idx_s1_q <= index_pin; idx_s2_q <= idx_s1_q;
            drq_s1_q <= drq_in;    drq_s2_q <= drq_s1_q;
            wg_s1_q  <= write_gate; wg_s2_q <= wg_s1_q;
        end
    end

    assign cmd_wr    = hp.wr && hp.addr == PORT_STATUS && !busy_q;
    assign fd_wr     = hp.wr && hp.addr == PORT_CONTROL;
    assign srst_rise = fd_wr && hp.wdata[FD_SRST] && !fixed_q[FD_SRST];
    assign dev_reset = srst_q;

    always_comb begin
        // Drive ready/fault copies are shown as written; abort is firmware's job
        status = {busy_q, (sdh_q[SDH_DRIVE] ? drv1_q[6:4] : drv0_q[6:4]),
                  drq_s2_q,
                  (sdh_q[SDH_DRIVE] ? drv1_q[2] : drv0_q[2]),
                  idx_s2_q,
                  (sdh_q[SDH_DRIVE] ? drv1_q[0] : drv0_q[0])};
    end

    // Task-file copy: only the drive/head copy is held here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sdh_q <= RESET_BYTE;
        else if (hp.wr && hp.addr == PORT_SDH && !busy_q) sdh_q <= hp.wdata;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fixed_q <= RESET_BYTE;
        end else if (fd_wr) begin
            fixed_q <= hp.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) srst_q <= 1'b0;
        else srst_q <= fixed_q[FD_SRST];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) reset_out <= 1'b0;
        else reset_out <= fixed_q[FD_SRST] && !rdis_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) hs3_rwc <= 1'b0;
        else hs3_rwc <= fixed_q[FD_HEAD3_SELECT_ENABLE] ? sdh_q[SDH_HS3] : rwc_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) sdh_out <= RESET_BYTE;
        else sdh_out <= sdh_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) cmd_q <= RESET_BYTE;
        else if (cmd_wr) cmd_q <= hp.wdata;
    end

    // Busy: set wins over the micro's clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) busy_q <= 1'b1;
        else if (cmd_wr || dev_reset || master_rst) busy_q <= 1'b1;
        else if (u_wr && u_addr == UREG_CTRL && u_wdata[0]) busy_q <= 1'b0;
    end

    // Raise from micro wins over host acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) irq_q <= 1'b0;
        else if (master_rst || dev_reset) irq_q <= 1'b0;
        else if (u_wr && u_addr == UREG_CTRL && u_wdata[1]
                 && !fixed_q[FD_IDIS_N]) irq_q <= 1'b1;
        else if (cmd_wr || (hp.rd && hp.addr == PORT_STATUS)) irq_q <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) mint_q <= 1'b0;
        else if (cmd_wr || (srst_rise && rdis_q)) mint_q <= 1'b1;
        else if (u_rd && u_addr == UREG_CMD) mint_q <= 1'b0;
    end
    assign micro_int = mint_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drv0_q <= 7'h00; drv1_q <= 7'h00; rwc_q <= 1'b0; rdis_q <= 1'b0;
        end else if (u_wr) begin
            if (u_addr == UREG_DRV0) drv0_q <= u_wdata[6:0];
            if (u_addr == UREG_DRV1) drv1_q <= u_wdata[6:0];
            if (u_addr == UREG_CTRL) begin
                rwc_q  <= u_wdata[2];
                rdis_q <= u_wdata[3];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) u_rdata <= RESET_BYTE;
        else if (u_rd) begin
            case (u_addr)
                UREG_CMD:   u_rdata <= cmd_q;
                UREG_FIXED: u_rdata <= fixed_q;
                UREG_FLAGS: u_rdata <= {4'h0, srst_q, mint_q, irq_q, busy_q};
                UREG_DRV0:  u_rdata <= {1'b0, drv0_q};
                UREG_DRV1:  u_rdata <= {1'b0, drv1_q};
                default:    u_rdata <= RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hp.rdata <= RESET_BYTE; hp.rdata7_oe <= 1'b0;
        end else if (hp.rd) begin
            hp.rdata7_oe <= 1'b1;
            if (hp.addr == PORT_STATUS || hp.addr == PORT_CONTROL)
                hp.rdata <= status;
            else if (hp.addr == PORT_DIGITAL) begin
                hp.rdata     <= {1'b0, wg_s2_q,
                                 (fixed_q[FD_HEAD3_SELECT_ENABLE] ? sdh_q[SDH_HS3] : rwc_q),
                                 sdh_q[2:0], sdh_q[SDH_DRIVE], !sdh_q[SDH_DRIVE]};
                hp.rdata7_oe <= 1'b0;
            end else if (busy_q && hp.addr >= PORT_TASK_LO && hp.addr <= PORT_STATUS)
                hp.rdata <= status;
            else if (hp.addr == PORT_SDH)
                hp.rdata <= sdh_q;
            else
                hp.rdata <= RESET_BYTE;
        end else begin
            hp.rdata7_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hp.irq_o <= 1'b0; hp.irq_oe <= 1'b1;
        end else begin
            hp.irq_o  <= irq_q;
            hp.irq_oe <= !fixed_q[FD_IDIS_N];
        end
    end
endmodule : athsp_dev
`default_nettype wire

/* shared/athsp_pkg.sv */
// Purpose: Shared constants for the AT host status and control ports.
// Assumes: 8-bit host port, 4-bit port address, 100 MHz clock.
// Notes:   Port offsets, status bit positions and timing counts.
package athsp_pkg;
    localparam logic [3:0] PORT_STATUS    = 4'h7;  // Read status, write command
    localparam logic [3:0] PORT_CONTROL   = 4'he;  // Read alt status, write fixed disk
    localparam logic [3:0] PORT_DIGITAL   = 4'hf;  // Read digital input
    localparam logic [3:0] PORT_TASK_LO   = 4'h1;  // First task-file copy port
    localparam logic [3:0] PORT_SDH       = 4'h6;  // Drive/head select copy
    localparam int BIT_BUSY   = 7;
    localparam int BIT_READY  = 6;
    localparam int BIT_WFAULT = 5;
    localparam int BIT_SEEK   = 4;
    localparam int BIT_DRQ    = 3;
    localparam int BIT_CORR   = 2;
    localparam int BIT_INDEX  = 1;
    localparam int BIT_ERR    = 0;
    localparam int FD_HEAD3_SELECT_ENABLE   = 3;
    localparam int FD_SRST    = 2;
    localparam int FD_IDIS_N  = 1;
    localparam int SDH_DRIVE  = 4;
    localparam int SDH_HS3    = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CLK_MHZ         = 100;
    localparam int SRST_MIN_NS     = 5000;     // 5.0 us soft reset hold
    localparam int SRST_MIN_CYCLES = (SRST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0] SRST_CNT_W = 10'(SRST_MIN_CYCLES);
    // Micro register offsets (designer's own)
    localparam logic [2:0] UREG_DRV0    = 3'h0;  // Drive 0 status bits 6..0 write
    localparam logic [2:0] UREG_DRV1    = 3'h1;  // Drive 1 status
    localparam logic [2:0] UREG_CTRL    = 3'h2;  // b0 clear busy, b1 raise irq, b2 rwc, b3 reset dis
    localparam logic [2:0] UREG_CMD     = 3'h3;  // Read command byte, clears micro irq
    localparam logic [2:0] UREG_FIXED   = 3'h4;  // Read fixed disk byte
    localparam logic [2:0] UREG_FLAGS   = 3'h5;  // Read busy, irq, micro irq, srst cause
endpackage : athsp_pkg

/* shared/athsp_if.sv */
// Purpose: Host port wires between AT host end and the controller end.
// Assumes: One clock; host strobes are single cycle.
// Notes:   Interrupt line is three-state; resolved from the enable.
`timescale 1ns/1ps
`default_nettype none
interface athsp_if;
    logic [3:0] addr;       // Port address
    logic [7:0] wdata;      // Host write data
    logic       wr;         // Host write strobe
    logic       rd;         // Host read strobe
    logic [7:0] rdata;      // Read data, cycle after rd
    logic       rdata7_oe;  // High while bit 7 of rdata is driven
    logic       irq_o;      // Interrupt level
    logic       irq_oe;     // Interrupt pin enable
    logic       irq_wire;   // Resolved pin, low when floating
    assign irq_wire = irq_oe & irq_o;
    modport dev  (input addr, wdata, wr, rd, output rdata, rdata7_oe, irq_o, irq_oe);
    modport host (output addr, wdata, wr, rd, input rdata, rdata7_oe, irq_wire);
endinterface : athsp_if
`default_nettype wire

/* rtl/athsp_host.sv */
// Purpose: AT host end; turns user orders into single-cycle port strobes.
// Assumes: User issues one order at a time and waits for done.
// Notes:   Soft reset writes are held at least the minimum time.
`timescale 1ns/1ps
`default_nettype none
module athsp_host
    import athsp_pkg::*;
(
    input  wire logic       clk,        // 100 MHz clock
    input  wire logic       rst,        // Reset
    athsp_if.host           hp,         // Host port
    input  wire logic       req,        // Order pulse
    input  wire logic       req_wr,     // 1 write, 0 read
    input  wire logic [3:0] req_addr,   // Port address
    input  wire logic [7:0] req_data,   // Write data
    output logic            done,       // Order finished pulse
    output logic      [7:0] rd_data,    // Read result
    output logic            irq_seen    // Synchronised interrupt pin
);
    typedef enum {ST_IDLE, ST_READ, ST_HOLD} athsp_st_t;
    athsp_st_t  st_q;
    logic [9:0] hold_q;
    logic       irq_s1_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_s1_q <= 1'b0; irq_seen <= 1'b0;
        end else begin
            irq_s1_q <= hp.irq_wire; irq_seen <= irq_s1_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE; hold_q <= 10'h000; done <= 1'b0; rd_data <= 8'h00;
            hp.wr <= 1'b0; hp.rd <= 1'b0; hp.addr <= 4'h0; hp.wdata <= 8'h00;
        end else begin
            hp.wr <= 1'b0;
            hp.rd <= 1'b0;
            done  <= 1'b0;
            case (st_q)
                ST_IDLE: if (req) begin
                    hp.addr  <= req_addr;
                    hp.wdata <= req_data;
                    if (!req_wr) begin
                        hp.rd <= 1'b1;
                        st_q  <= ST_READ;
                    end else begin
                        hp.wr <= 1'b1;
                        if (req_addr == PORT_CONTROL && req_data[FD_SRST]) begin
                            hold_q <= SRST_CNT_W;
                            st_q   <= ST_HOLD;
                        end else begin
                            done <= 1'b1;
                        end
                    end
                end
                ST_READ: st_q <= ST_HOLD;
                ST_HOLD: begin
                    if (hold_q != 10'h000) hold_q <= hold_q - 10'h001;
                    else begin
                        if (!hp.wr && hp.rd == 1'b0) rd_data <= hp.rdata;
                        done <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule : athsp_host
`default_nettype wire

/* test/athsp_asserts.sv */
// Purpose: Port timing checks between the two ends.
// Assumes: One clock; bench holds drive pins still near status reads.
// Notes:   Watches the interface wires only.
`timescale 1ns/1ps
`default_nettype none
module athsp_asserts
    import athsp_pkg::*;
(
    input wire logic       clk,       // Clock
    input wire logic       rst,       // Reset
    input wire logic [3:0] addr,      // Port
    input wire logic [7:0] wdata,     // Write data
    input wire logic       wr,        // Write strobe
    input wire logic       rd,        // Read strobe
    input wire logic [7:0] rdata,     // Read data
    input wire logic       rdata7_oe, // Bit 7 enable
    input wire logic       irq_o,     // Interrupt level
    input wire logic       irq_oe     // Interrupt enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_status_read_ack: assert property (rd && addr == PORT_STATUS |-> ##2 !irq_o)
        else $error("status read left interrupt set");
    chk_cmd_sets_busy: assert property (wr && addr == PORT_STATUS ##1 rd && addr == PORT_STATUS
        |=> rdata[BIT_BUSY])
        else $error("busy not set after command");
    chk_alt_keeps_irq: assert property (rd && addr == PORT_CONTROL && irq_o && !$past(wr)
        && !$past(wr, 2) |=> irq_o)
        else $error("alternate read cleared interrupt");
    chk_digin_bit_float: assert property (rd && addr == PORT_DIGITAL |=> !rdata7_oe)
        else $error("bit 7 driven on digital read");
    chk_bit_seven_driven: assert property (rd && addr != PORT_DIGITAL |=> rdata7_oe)
        else $error("bit 7 floating on other read");
    chk_alt_mirror: assert property (rd && addr == PORT_STATUS ##1 rd && addr == PORT_CONTROL
        |=> rdata == $past(rdata))
        else $error("alternate status differs");
    chk_irq_pin_off: assert property (wr && addr == PORT_CONTROL && wdata[FD_IDIS_N]
        |-> ##[1:2] !irq_oe)
        else $error("pin not floated");
    chk_irq_pin_on: assert property (wr && addr == PORT_CONTROL && !wdata[FD_IDIS_N]
        |-> ##[1:2] irq_oe)
        else $error("pin not enabled");
    chk_pending_kept: assert property (wr && addr == PORT_CONTROL && wdata[FD_IDIS_N]
        && !wdata[FD_SRST] && irq_o |=> irq_o [*2])
        else $error("disable dropped pending interrupt");
endmodule : athsp_asserts
`default_nettype wire

/* test/athsp_tb.sv */
// Purpose: Drives both ends through host and micro orders.
// Assumes: Host orders wait for done; micro port per the hand-over.
// Notes:   Drive pins held still around status reads.
`timescale 1ns/1ps
`default_nettype none
module athsp_tb;
    import athsp_pkg::*;
    logic clk = 0, rst = 1, master_rst = 0, u_wr = 0, u_rd = 0, micro_int, drq_in = 0;
    logic index_pin = 0, write_gate = 0, reset_out, hs3_rwc, req = 0, req_wr = 0, done;
    logic       irq_seen;
    logic [2:0] u_addr = 0;
    logic [3:0] req_addr = 0;
    logic [7:0] u_wdata = 0, u_rdata, req_data = 0, rd_data, v, sdh_seen;
    int         mismatches = 0, samples_checked = 0, cycles = 0;
    athsp_if hp_if ();
    athsp_dev athsp_dev_inst (.clk(clk), .rst(rst), .master_rst(master_rst), .hp(hp_if),
        .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata),
        .micro_int(micro_int), .drq_in(drq_in), .index_pin(index_pin),
        .write_gate(write_gate), .reset_out(reset_out), .hs3_rwc(hs3_rwc), .sdh_out(sdh_seen));
    athsp_host athsp_host_inst (.clk(clk), .rst(rst), .hp(hp_if), .req(req), .req_wr(req_wr),
        .req_addr(req_addr), .req_data(req_data), .done(done), .rd_data(rd_data),
        .irq_seen(irq_seen));
    athsp_asserts athsp_asserts_inst (.clk(clk), .rst(rst), .addr(hp_if.addr),
        .wdata(hp_if.wdata), .wr(hp_if.wr), .rd(hp_if.rd), .rdata(hp_if.rdata),
        .rdata7_oe(hp_if.rdata7_oe), .irq_o(hp_if.irq_o), .irq_oe(hp_if.irq_oe));
    always #5 clk = ~clk;
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic host(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        req <= 1'b1;
        req_wr <= w;
        req_addr <= a;
        req_data <= d;
        @(posedge clk);
        req <= 1'b0;
        #1;
        for (n = 0; n < 2000 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask : host
    task automatic mwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        u_wr <= 1'b1;
        u_addr <= a;
        u_wdata <= d;
        @(posedge clk);
        u_wr <= 1'b0;
    endtask : mwr
    task automatic mrd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        u_rd <= 1'b1;
        u_addr <= a;
        @(posedge clk);
        u_rd <= 1'b0;
        #1;
        d = u_rdata;
    endtask : mrd
    task automatic irq_is(input logic e);
        int n;
        for (n = 0; n < 10 && irq_seen !== e; n++) begin
            @(posedge clk);
            #1;
        end
        check("irq_seen", {7'h0, e}, {7'h0, irq_seen});
    endtask : irq_is
    task automatic t_status();
        host(0, PORT_STATUS, 0);
        check("reset status", 8'h80, rd_data);
        check("irq_oe", 8'h01, {7'h0, hp_if.irq_oe});
        mwr(UREG_DRV0, 8'h75);
        mwr(UREG_DRV1, 8'h44);
        mwr(UREG_CTRL, 8'h01);
        drq_in <= 1'b1;
        index_pin <= 1'b1;
        repeat (4) @(posedge clk);
        host(0, PORT_STATUS, 0);
        check("status", 8'h7f, rd_data);
        host(0, PORT_CONTROL, 0);
        check("alt status", 8'h7f, rd_data);
        drq_in <= 1'b0;
        index_pin <= 1'b0;
        host(1, PORT_SDH, 8'h15);
        repeat (4) @(posedge clk);
        host(0, PORT_STATUS, 0);
        check("drive1 status", 8'h44, rd_data);
        check("sdh_out", 8'h15, sdh_seen);
        $display("test status done");
    endtask : t_status
    task automatic t_digital();
        write_gate <= 1'b1;
        host(1, PORT_CONTROL, 8'h08);
        mrd(UREG_FIXED, v);
        check("fixed byte", 8'h08, v);
        repeat (4) @(posedge clk);
        host(0, PORT_DIGITAL, 0);
        check("digital hs3", 8'h56, {1'b0, rd_data[6:0]});
        check("hs3_rwc", 8'h00, {7'h0, hs3_rwc});
        host(1, PORT_CONTROL, 8'h00);
        mwr(UREG_CTRL, 8'h04);
        host(0, PORT_DIGITAL, 0);
        check("digital rwc", 8'h76, {1'b0, rd_data[6:0]});
        check("hs3_rwc", 8'h01, {7'h0, hs3_rwc});
        $display("test digital done");
    endtask : t_digital
    task automatic t_irq();
        mwr(UREG_CTRL, 8'h02);
        irq_is(1'b1);
        host(0, PORT_CONTROL, 0);
        irq_is(1'b1);
        host(1, PORT_CONTROL, 8'h02);
        irq_is(1'b0);
        host(1, PORT_CONTROL, 8'h00);
        irq_is(1'b1);
        host(0, PORT_STATUS, 0);
        irq_is(1'b0);
        mwr(UREG_CTRL, 8'h02);
        irq_is(1'b1);
        host(1, PORT_STATUS, 8'hec);
        irq_is(1'b0);
        check("micro_int", 8'h01, {7'h0, micro_int});
        host(0, PORT_TASK_LO, 0);
        check("busy task read", 8'hc4, rd_data);
        mrd(UREG_CMD, v);
        check("command", 8'hec, v);
        $display("test irq done");
    endtask : t_irq
    task automatic t_reset();
        host(1, PORT_CONTROL, 8'h04);
        check("reset_out", 8'h01, {7'h0, reset_out});
        host(0, PORT_STATUS, 0);
        check("busy", 8'h01, {7'h0, rd_data[7]});
        host(1, PORT_CONTROL, 8'h00);
        repeat (3) @(posedge clk);
        check("reset_out", 8'h00, {7'h0, reset_out});
        mwr(UREG_CTRL, 8'h0a);
        irq_is(1'b1);
        host(1, PORT_CONTROL, 8'h02);
        @(posedge clk);
        master_rst <= 1'b1;
        @(posedge clk);
        master_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq master", 8'h00, {6'h0, hp_if.irq_oe, hp_if.irq_o});
        host(1, PORT_CONTROL, 8'h04);
        check("masked reset", 8'h01, {6'h0, reset_out, micro_int});
        host(1, PORT_CONTROL, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_status();
        t_digital();
        t_irq();
        t_reset();
        results();
    end
endmodule : athsp_tb
`default_nettype wire
